// [hw/vic_pkg.sv]
/*
 Package for the vectored interrupt control block: data addresses, field
 positions, reset values, source indices and timing constants.
 Assumes a 4-bit data memory space with 12-bit data addresses.
*/
package vic_pkg;
    // Data addresses of the registers.
    localparam logic [11:0] PRIORITY_SELECT_ADDR = 12'hfb2;
    localparam logic [11:0] PIN0_EDGE_MODE_ADDR = 12'hfb4;
    localparam logic [11:0] PIN1_EDGE_MODE_ADDR = 12'hfb5;
    localparam logic [11:0] REQ_FLAGS_LO_ADDR = 12'hfb8;
    localparam logic [11:0] REQ_FLAGS_MID_ADDR = 12'hfb9;
    localparam logic [11:0] REQ_FLAGS_HI_ADDR = 12'hfba;
    localparam logic [11:0] EN_FLAGS_LO_ADDR = 12'hfbc;
    localparam logic [11:0] EN_FLAGS_MID_ADDR = 12'hfbd;
    localparam logic [11:0] EN_FLAGS_HI_ADDR = 12'hfbe;
    // Reset values.
    localparam logic [3:0] PRIORITY_SELECT_RESET = 4'h0;
    localparam logic [3:0] EDGE_MODE_RESET = 4'h0;
    localparam logic [9:0] FLAGS_RESET = 10'h000;
    // Field positions.
    localparam int MASTER_ENABLE_BIT = 3;
    localparam int SAMPLE_CLOCK_SELECT_BIT = 3;
    localparam int IRQ_STATUS_HIGH_BIT = 3;
    localparam int IRQ_STATUS_LOW_BIT = 2;
    // Edge mode codes in bits 1:0.
    localparam logic [1:0] EDGE_RISING = 2'h0;
    localparam logic [1:0] EDGE_FALLING = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Source indices within the ten flag vectors.
    localparam int SRC_INTERVAL_TIMER = 0;
    localparam int SRC_PIN4 = 1;
    localparam int SRC_PIN0 = 2;
    localparam int SRC_PIN1 = 3;
    localparam int SRC_SERIAL0 = 4;
    localparam int SRC_COUNTER0 = 5;
    localparam int SRC_PULSE_GEN = 6;
    localparam int SRC_KEYSCAN = 7;
    localparam int SRC_PIN2 = 8;
    localparam int SRC_WATCH = 9;
    localparam int NUM_SOURCES = 10;
    // Timing.
    localparam int CLK_FREQ_HZ = 20000000;
    localparam int OSC_DIVIDE = 64;
    localparam int PIN0_FILTER_SAMPLES = 2;
    // Register bus request.
    typedef struct packed {
        logic rd;
        logic wr;
        logic bit_access;
        logic [1:0] bit_sel;
        logic [11:0] addr;
        logic [3:0] wdata;
    } vic_bus_req_t;
    // Acknowledge from the CPU core.
    typedef struct packed {
        logic ack;
        logic [2:0] vector;
    } vic_ack_t;
endpackage : vic_pkg

// [hw/vic_top.sv]
/*
 Vectored interrupt control: request and enable flags, edge detectors with
 a noise filter on pin 0, master enable, priority select and status.
 Assumes single-cycle 4-bit or single-bit data memory accesses from the CPU,
 one-cycle event pulses from peripherals, and inputs synchronous to clk.
*/
`timescale 1ns/10ps
// How it works
// - Ten request flags, each with enable.
// - Flag sets on request, clears on service.
// - Shared vector pair clears differently.
// - Enabled pending flag 0..7 raises vector request.
// - Vector request also wakes from standby.
// - Flags reachable by bit and nibble.
// - Software-set flag is serviced like hardware.
// - Reset clears all request and enable flags.
// - Pin 4 sets on either edge.
// - Internal sources set their own flags.
// - Pin 2 sets on rising edge only.
// - Pin 0 filter needs two equal samples.
// - Mode bit 3 picks pin 0 sample clock.
// - Pin 0 detector stops in standby.
// - Edge mode registers nibble-written, reset zero.
// - Low three priority bits pick high vector.
// - Bit 3 is master enable, instruction-driven.
// - Priority select at FB2H, reset zero.
// - Status flags sit at word bits 3,2.
// - Status 0 any, 1 high only, 2 none.
// - Lowest-numbered vector wins simultaneous requests.
// - Test sources never raise a vector.
// - Both shared sources: OR, no clear.
module vic_top #(
    parameter int OSC_DIV = vic_pkg::OSC_DIVIDE
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Data memory access
    input wire vic_pkg::vic_bus_req_t bus_req,
    output logic [3:0] bus_rdata,
    // Instruction controls
    input wire logic irq_enable_op,
    input wire logic irq_disable_op,
    // Status word bits 3:2 write and interrupt return restore
    input wire logic status_write,
    input wire logic [1:0] status_wdata,
    // CPU acknowledge
    input wire vic_pkg::vic_ack_t cpu_ack,
    // Standby and oscillator divider tick
    input wire logic standby,
    input wire logic osc_tick,
    // Internal event pulses
    input wire logic interval_timer_event,
    input wire logic serial0_event,
    input wire logic counter0_event,
    input wire logic pulse_gen_event,
    input wire logic keyscan_event,
    input wire logic watch_event,
    // External pins
    input wire logic ext_irq_pin0,
    input wire logic ext_irq_pin1,
    input wire logic ext_irq_pin2,
    input wire logic ext_irq_pin4,
    // To the CPU core
    output logic irq_pending,
    output logic [2:0] irq_vector,
    output logic [3:0] program_status_word,
    output logic wake_up
);
    logic [9:0] req_q;
    logic [9:0] req_d;
    logic [9:0] en_q;
    logic [9:0] en_d;
    logic [3:0] priority_select_q;
    logic [3:0] pin0_edge_mode_q;
    logic [3:0] pin1_edge_mode_q;
    logic [1:0] status_q;
    logic [2:0] sync0_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] sync4_q;
    logic [1:0] filt_q;
    logic filt_out_q;
    logic [3:0] rdata_q;
    logic pend_q;
    logic [2:0] vec_q;
    logic wake_q;

    function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic cur);
        logic r;
        logic f;
        r = cur & ~prev;
        f = prev & ~cur;
        case (mode)
            vic_pkg::EDGE_RISING: edge_hit = r;
            vic_pkg::EDGE_FALLING: edge_hit = f;
            vic_pkg::EDGE_BOTH: edge_hit = r | f;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    function automatic logic [3:0] nib_wr(input logic [3:0] old, input vic_pkg::vic_bus_req_t rq);
        logic [3:0] n;
        n = old;
        if (rq.bit_access)
        begin
            n[rq.bit_sel] = rq.wdata[0];
        end
        else
        begin
            n = rq.wdata;
        end
        nib_wr = n;
    endfunction : nib_wr

    // Pin synchronisers; stage 0 is read only by stage 1.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync0_q <= 3'h0;
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            sync4_q <= 3'h0;
        end
        else
        begin
            sync0_q <= {sync0_q[1:0], ext_irq_pin0};
            sync1_q <= {sync1_q[1:0], ext_irq_pin1};
            sync2_q <= {sync2_q[1:0], ext_irq_pin2};
            sync4_q <= {sync4_q[1:0], ext_irq_pin4};
        end
    end

    // Pin 0 noise filter, sampled by clk or by the divided oscillator tick.
    wire sample_en = pin0_edge_mode_q[vic_pkg::SAMPLE_CLOCK_SELECT_BIT] ? osc_tick :
        1'b1;
    wire filt_step = sample_en & ~standby;
    wire filt_agree = (filt_q[0] == filt_q[1]);
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            filt_q <= 2'h0;
            filt_out_q <= 1'b0;
        end
        else if (filt_step)
        begin
            filt_q <= {filt_q[0], sync0_q[1]};
            if (filt_agree)
            begin
                filt_out_q <= filt_q[1];
            end
        end
    end
    logic filt_prev_q;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            filt_prev_q <= 1'b0;
        end
        else
        begin
            filt_prev_q <= filt_out_q;
        end
    end

    // Event vector.
    wire pin0_edge = ~standby &
        edge_hit(pin0_edge_mode_q[1:0], filt_prev_q, filt_out_q);
    wire pin1_edge = edge_hit(pin1_edge_mode_q[1:0], sync1_q[2], sync1_q[1]);
    wire pin2_edge = sync2_q[1] & ~sync2_q[2];
    wire pin4_edge = sync4_q[1] ^ sync4_q[2];
    wire [9:0] hw_set = {watch_event, pin2_edge, keyscan_event, pulse_gen_event,
        counter0_event, serial0_event, pin1_edge, pin0_edge, pin4_edge,
        interval_timer_event};

    // Vector arbitration.
    wire master_en = priority_select_q[vic_pkg::MASTER_ENABLE_BIT];
    wire [9:0] enabled = req_q & en_q;
    wire [7:1] vrq = {enabled[7:2], enabled[1] | enabled[0]};
    wire [2:0] high_vec = priority_select_q[2:0];
    logic [2:0] win_vec;
    logic win_any;
    always_comb
    begin
        win_vec = 3'h0;
        win_any = 1'b0;
        for (int i = 7; i >= 1; i--)
        begin
            if (vrq[i] && (status_q == 2'h0 || (status_q == 2'h1 && high_vec == 3'(i))))
            begin
                win_vec = 3'(i);
                win_any = 1'b1;
            end
        end
    end
    wire both_shared = en_q[vic_pkg::SRC_INTERVAL_TIMER] & en_q[vic_pkg::SRC_PIN4];

    // Acknowledge clearing.
    logic [9:0] ack_clr;
    always_comb
    begin
        ack_clr = 10'h000;
        if (cpu_ack.ack)
        begin
            if (cpu_ack.vector == 3'h1)
            begin
                if (!both_shared)
                begin
                    ack_clr[vic_pkg::SRC_INTERVAL_TIMER] = en_q[vic_pkg::SRC_INTERVAL_TIMER];
                    ack_clr[vic_pkg::SRC_PIN4] = en_q[vic_pkg::SRC_PIN4];
                end
            end
            else if (cpu_ack.vector != 3'h0)
            begin
                ack_clr[cpu_ack.vector] = 1'b1;
            end
        end
    end

    // Flag register access; index 0..3 low nibble, 4..7 mid, 8..9 high.
    wire wr = bus_req.wr;
    wire [1:0] grp_req = bus_req.addr == vic_pkg::REQ_FLAGS_LO_ADDR ? 2'h1 :
        bus_req.addr == vic_pkg::REQ_FLAGS_MID_ADDR ? 2'h2 :
        bus_req.addr == vic_pkg::REQ_FLAGS_HI_ADDR ? 2'h3 : 2'h0;
    wire [1:0] grp_en = bus_req.addr == vic_pkg::EN_FLAGS_LO_ADDR ? 2'h1 :
        bus_req.addr == vic_pkg::EN_FLAGS_MID_ADDR ? 2'h2 :
        bus_req.addr == vic_pkg::EN_FLAGS_HI_ADDR ? 2'h3 : 2'h0;
    wire [11:0] req_ext = {2'h0, req_q};
    wire [11:0] en_ext = {2'h0, en_q};
    wire [11:0] req_wv = {nib_wr(req_ext[11:8], bus_req), nib_wr(req_ext[7:4], bus_req),
        nib_wr(req_ext[3:0], bus_req)};
    wire [11:0] en_wv = {nib_wr(en_ext[11:8], bus_req), nib_wr(en_ext[7:4], bus_req),
        nib_wr(en_ext[3:0], bus_req)};
    always_comb
    begin
        req_d = req_q & ~ack_clr;
        en_d = en_q;
        case (grp_req)
            2'h1: if (wr) req_d[3:0] = req_wv[3:0] & ~ack_clr[3:0];
            2'h2: if (wr) req_d[7:4] = req_wv[7:4] & ~ack_clr[7:4];
            2'h3: if (wr) req_d[9:8] = req_wv[9:8];
            default: req_d = req_d;
        endcase
        case (grp_en)
            2'h1: if (wr) en_d[3:0] = en_wv[3:0];
            2'h2: if (wr) en_d[7:4] = en_wv[7:4];
            2'h3: if (wr) en_d[9:8] = en_wv[9:8];
            default: en_d = en_d;
        endcase
        req_d = req_d | hw_set;
    end

    wire [11:0] other_addr = bus_req.addr;
    wire prio_sel_wr = wr & (other_addr == vic_pkg::PRIORITY_SELECT_ADDR);
    wire pin0_mode_wr = wr & ~bus_req.bit_access & (other_addr == vic_pkg::PIN0_EDGE_MODE_ADDR);
    wire pin1_mode_wr = wr & ~bus_req.bit_access & (other_addr == vic_pkg::PIN1_EDGE_MODE_ADDR);
    logic [3:0] priority_select_d;
    always_comb
    begin
        priority_select_d = prio_sel_wr ? nib_wr(priority_select_q, bus_req) : priority_select_q;
        if (irq_enable_op)
        begin
            priority_select_d[vic_pkg::MASTER_ENABLE_BIT] = 1'b1;
        end
        if (irq_disable_op)
        begin
            priority_select_d[vic_pkg::MASTER_ENABLE_BIT] = 1'b0;
        end
    end

    wire take = master_en & win_any & ~cpu_ack.ack;
    wire [1:0] status_next = (status_q == 2'h0) ? 2'h1 : 2'h2;
    wire [3:0] rd_mux = (grp_req != 2'h0) ? req_ext[4 * grp_req - 4 +: 4] :
        (grp_en != 2'h0) ? en_ext[4 * grp_en - 4 +: 4] :
        (other_addr == vic_pkg::PRIORITY_SELECT_ADDR) ? priority_select_q :
        (other_addr == vic_pkg::PIN0_EDGE_MODE_ADDR) ? pin0_edge_mode_q :
        (other_addr == vic_pkg::PIN1_EDGE_MODE_ADDR) ? pin1_edge_mode_q : 4'h0;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            req_q <= vic_pkg::FLAGS_RESET;
            en_q <= vic_pkg::FLAGS_RESET;
            priority_select_q <= vic_pkg::PRIORITY_SELECT_RESET;
            pin0_edge_mode_q <= vic_pkg::EDGE_MODE_RESET;
            pin1_edge_mode_q <= vic_pkg::EDGE_MODE_RESET;
            status_q <= 2'h0;
            rdata_q <= 4'h0;
            pend_q <= 1'b0;
            vec_q <= 3'h0;
            wake_q <= 1'b0;
        end
        else
        begin
            req_q <= req_d;
            en_q <= en_d;
            priority_select_q <= priority_select_d;
            if (pin0_mode_wr)
            begin
                pin0_edge_mode_q <= bus_req.wdata;
            end
            if (pin1_mode_wr)
            begin
                pin1_edge_mode_q <= bus_req.wdata;
            end
            if (status_write)
            begin
                status_q <= (status_wdata == 2'h3) ? status_q : status_wdata;
            end
            else if (cpu_ack.ack && status_q != 2'h2)
            begin
                status_q <= status_next;
            end
            rdata_q <= bus_req.rd ? (bus_req.bit_access ? {3'h0, rd_mux[bus_req.bit_sel]} :
                rd_mux) : 4'h0;
            pend_q <= take;
            vec_q <= take ? win_vec : 3'h0;
            wake_q <= |vrq;
        end
    end

    assign bus_rdata = rdata_q;
    assign irq_pending = pend_q;
    assign irq_vector = vec_q;
    assign program_status_word = {status_q, 2'h0};
    assign wake_up = wake_q;

    chk_reset_clear: assert property (
        @(posedge clk) $fell(reset) |-> (req_q == 10'h000 && en_q == 10'h000))
        else $error("flags not cleared by reset");
    chk_test_novec: assert property (
        @(posedge clk) disable iff (reset) ((req_q[7:0] & en_q[7:0]) == 8'h00) |=> !pend_q)
        else $error("vector raised without vectored request");
    chk_master_gate: assert property (
        @(posedge clk) disable iff (reset) !master_en |=> !pend_q)
        else $error("request while master disabled");
    chk_status_none: assert property (
        @(posedge clk) disable iff (reset) status_q == 2'h2 |=> !pend_q)
        else $error("request in status 2");
    chk_status_legal: assert property (
        @(posedge clk) disable iff (reset) status_q != 2'h3)
        else $error("status 3 reached");
    chk_pin2_rise: assert property (
        @(posedge clk) disable iff (reset) sync2_q[1] && !sync2_q[2] |=> req_q[vic_pkg::SRC_PIN2])
        else $error("pin2 rise missed");
    chk_pin4_edge: assert property (
        @(posedge clk) disable iff (reset) sync4_q[1] != sync4_q[2] |=> req_q[vic_pkg::SRC_PIN4])
        else $error("pin4 edge missed");
    chk_wake_req: assert property (
        @(posedge clk) disable iff (reset) (|(req_q[7:0] & en_q[7:0])) |=> wake_q)
        else $error("wake missing");
    chk_shared_keep: assert property (
        @(posedge clk) disable iff (reset) cpu_ack.ack && cpu_ack.vector == 3'h1 && both_shared
            && req_q[vic_pkg::SRC_PIN4] |=> req_q[vic_pkg::SRC_PIN4])
        else $error("shared flag cleared");
endmodule : vic_top

// [tb/vic_cpu_model.sv]
/*
 CPU core model for the vectored interrupt control block: acknowledges an
 offered vector after a programmable number of cycles.
 Assumes the bench enables it and sets the delay between transfers.
*/
`timescale 1ns/10ps
module vic_cpu_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Bench controls
    input wire logic ack_on,
    input wire logic [3:0] ack_dly,
    // From the block
    input wire logic irq_pending,
    input wire logic [2:0] irq_vector,
    // To the block
    output vic_pkg::vic_ack_t cpu_ack
);
    logic [3:0] wait_q;

    // Acknowledges for one cycle; while idle, inverts the vector field every cycle.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wait_q <= 4'h0;
            cpu_ack <= '0;
        end
        else if (cpu_ack.ack || !irq_pending || !ack_on)
        begin
            wait_q <= 4'h0;
            cpu_ack <= '{ack: 1'b0, vector: ~cpu_ack.vector};
        end
        else if (wait_q == ack_dly)
        begin
            cpu_ack <= '{ack: 1'b1, vector: irq_vector};
        end
        else
        begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : vic_cpu_model

// [tb/tb.sv]
/*
 Testbench for the vectored interrupt control block: drives bus, controls,
 events and pins, and judges flags, vector and status.
 Assumes vic_cpu_model answers vector requests.
*/
`timescale 1ns/10ps
`define CHK(n, e, a) \
    begin \
        total_checks++; \
        if ((a) !== (e)) \
        begin \
            fails++; \
            $display("wrong value %s expected %0h seen %0h", n, e, a); \
        end \
    end
module tb;
    localparam logic [11:0] PSA = vic_pkg::PRIORITY_SELECT_ADDR;
    localparam logic [11:0] M0A = vic_pkg::PIN0_EDGE_MODE_ADDR;
    localparam logic [11:0] M1A = vic_pkg::PIN1_EDGE_MODE_ADDR;
    localparam logic [11:0] RQL = vic_pkg::REQ_FLAGS_LO_ADDR;
    localparam logic [11:0] RQM = vic_pkg::REQ_FLAGS_MID_ADDR;
    localparam logic [11:0] RQH = vic_pkg::REQ_FLAGS_HI_ADDR;
    localparam logic [11:0] ENL = vic_pkg::EN_FLAGS_LO_ADDR;
    localparam logic [11:0] ENM = vic_pkg::EN_FLAGS_MID_ADDR;
    localparam logic [11:0] ENH = vic_pkg::EN_FLAGS_HI_ADDR;
    logic clk = 1'b0;
    logic reset = 1'b1;
    vic_pkg::vic_bus_req_t req = '0;
    logic en_op = 1'b0;
    logic dis_op = 1'b0;
    logic sw = 1'b0;
    logic [1:0] swd = 2'h0;
    logic standby = 1'b0;
    logic osc = 1'b0;
    logic [5:0] div_q = 6'h00;
    logic [5:0] ev = 6'h00;
    logic [3:0] pin = 4'h0;
    logic ack_on = 1'b0;
    logic [3:0] ack_dly = 4'h0;
    vic_pkg::vic_ack_t ack;
    logic [3:0] rdata;
    logic pend;
    logic [2:0] vec;
    logic [3:0] status_word;
    logic wake;
    int fails = 0;
    int total_checks = 0;

    always #25 clk = ~clk;

    // Oscillator divider tick, one pulse every 64 cycles.
    always @(posedge clk)
    begin
        div_q <= div_q + 6'h01;
        osc <= (div_q == 6'h3f);
    end

    vic_top #(.OSC_DIV(64)) vic_top_inst (
        .clk(clk), .reset(reset), .bus_req(req), .bus_rdata(rdata),
        .irq_enable_op(en_op), .irq_disable_op(dis_op), .status_write(sw),
        .status_wdata(swd), .cpu_ack(ack), .standby(standby), .osc_tick(osc),
        .interval_timer_event(ev[0]), .serial0_event(ev[1]), .counter0_event(ev[2]),
        .pulse_gen_event(ev[3]), .keyscan_event(ev[4]), .watch_event(ev[5]),
        .ext_irq_pin0(pin[0]), .ext_irq_pin1(pin[1]), .ext_irq_pin2(pin[2]),
        .ext_irq_pin4(pin[3]), .irq_pending(pend), .irq_vector(vec),
        .program_status_word(status_word), .wake_up(wake)
    );

    vic_cpu_model vic_cpu_model_inst (
        .clk(clk), .reset(reset), .ack_on(ack_on), .ack_dly(ack_dly),
        .irq_pending(pend), .irq_vector(vec), .cpu_ack(ack)
    );

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    task automatic bus(input logic r, input logic [11:0] a, input logic [3:0] d,
                       input logic b, input logic [1:0] s);
        @(posedge clk);
        req <= '{rd: r, wr: !r, bit_access: b, bit_sel: s, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        #1;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [3:0] d);
        bus(1'b0, a, d, 1'b0, 2'h0);
    endtask : wr

    task automatic rdc(input string n, input logic [11:0] a, input logic [3:0] e);
        bus(1'b1, a, 4'h0, 1'b0, 2'h0);
        `CHK(n, e, rdata)
    endtask : rdc

    // Kind 0 enables, 1 disables, 2 writes the status flags.
    task automatic strobe(input logic [1:0] k, input logic [1:0] d);
        @(posedge clk);
        en_op <= (k == 2'h0);
        dis_op <= (k == 2'h1);
        sw <= (k == 2'h2);
        swd <= d;
        @(posedge clk);
        {en_op, dis_op, sw} <= 3'h0;
        #1;
    endtask : strobe

    task automatic evt(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= 6'h00;
        #1;
    endtask : evt

    task automatic lvl(input int i, input logic v, input int n);
        @(posedge clk);
        pin[i] <= v;
        repeat (n) @(posedge clk);
        #1;
    endtask : lvl

    task automatic wpend(input logic v);
        for (int i = 0; i < 40; i++)
        begin
            if (pend === v)
                return;
            @(posedge clk);
            #1;
        end
        fails++;
        $display("wrong value pending expected %0h seen %0h", v, pend);
        close_out();
    endtask : wpend

    task automatic t_reset();
        logic [11:0] adr [9];
        adr = '{PSA, M0A, M1A, RQL, RQM, RQH, ENL, ENM, ENH};
        `CHK("pending", 1'b0, pend)
        `CHK("status", 4'h0, status_word)
        foreach (adr[i]) rdc("reset value", adr[i], 4'h0);
        wr(12'hfb3, 4'hf);
        rdc("unmapped", 12'hfb3, 4'h0);
        bus(1'b0, M0A, 4'h1, 1'b1, 2'h0);
        rdc("mode bit write", M0A, 4'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_walk();
        bus(1'b0, ENM, 4'h1, 1'b1, 2'h0);
        rdc("serial0 enable", ENM, 4'h1);
        strobe(2'h0, 2'h0);
        ack_dly <= 4'h3;
        ack_on <= 1'b1;
        evt(1);
        wpend(1'b1);
        `CHK("vector", 3'h4, vec)
        `CHK("wake", 1'b1, wake)
        wpend(1'b0);
        `CHK("status", 4'h4, status_word)
        rdc("serial0 flag", RQM, 4'h0);
        ack_on <= 1'b0;
        strobe(2'h2, 2'h3);
        `CHK("status kept", 4'h4, status_word)
        strobe(2'h2, 2'h0);
        wr(ENM, 4'h0);
        $display("test walk done");
    endtask : t_walk

    task automatic t_prio();
        wr(ENM, 4'hf);
        wr(RQM, 4'ha);
        bus(1'b1, RQM, 4'h0, 1'b1, 2'h3);
        `CHK("keyscan flag bit", 4'h1, rdata)
        wpend(1'b1);
        `CHK("lowest vector", 3'h5, vec)
        strobe(2'h1, 2'h0);
        wpend(1'b0);
        wr(PSA, 4'h5);
        strobe(2'h0, 2'h0);
        rdc("priority", PSA, 4'hd);
        ack_dly <= 4'h0;
        ack_on <= 1'b1;
        wpend(1'b0);
        `CHK("status one", 4'h4, status_word)
        repeat (4) @(posedge clk);
        #1;
        `CHK("low blocked", 1'b0, pend)
        bus(1'b0, RQM, 4'h1, 1'b1, 2'h1);
        wpend(1'b1);
        `CHK("high vector", 3'h5, vec)
        wpend(1'b0);
        `CHK("status two", 4'h8, status_word)
        bus(1'b0, RQM, 4'h1, 1'b1, 2'h1);
        repeat (4) @(posedge clk);
        #1;
        `CHK("none in two", 1'b0, pend)
        ack_on <= 1'b0;
        strobe(2'h2, 2'h0);
        wpend(1'b1);
        `CHK("restored", 3'h5, vec)
        strobe(2'h1, 2'h0);
        wr(PSA, 4'h0);
        wr(RQM, 4'h0);
        wr(ENM, 4'h0);
        $display("test priority done");
    endtask : t_prio

    task automatic t_shared();
        wr(ENL, 4'h3);
        evt(0);
        strobe(2'h0, 2'h0);
        wpend(1'b1);
        `CHK("shared vector", 3'h1, vec)
        ack_on <= 1'b1;
        wpend(1'b0);
        ack_on <= 1'b0;
        rdc("shared kept", RQL, 4'h1);
        strobe(2'h2, 2'h0);
        wr(ENL, 4'h1);
        ack_on <= 1'b1;
        wpend(1'b1);
        wpend(1'b0);
        ack_on <= 1'b0;
        rdc("single cleared", RQL, 4'h0);
        strobe(2'h2, 2'h0);
        strobe(2'h1, 2'h0);
        wr(ENL, 4'h0);
        $display("test shared done");
    endtask : t_shared

    task automatic t_pins();
        logic [3:0] mode [3];
        logic [3:0] exp [3];
        mode = '{4'h1, 4'h3, 4'h2};
        exp = '{4'h8, 4'h8, 4'h0};
        lvl(3, 1'b1, 5);
        rdc("pin4 rise", RQL, 4'h2);
        wr(RQL, 4'h0);
        lvl(3, 1'b0, 5);
        rdc("pin4 fall", RQL, 4'h2);
        wr(RQL, 4'h0);
        wr(ENH, 4'h3);
        strobe(2'h0, 2'h0);
        lvl(2, 1'b1, 5);
        rdc("pin2 rise", RQH, 4'h1);
        `CHK("test source", 1'b0, pend)
        wr(RQH, 4'h0);
        lvl(2, 1'b0, 5);
        rdc("pin2 fall", RQH, 4'h0);
        evt(5);
        rdc("watch", RQH, 4'h2);
        `CHK("watch source", 1'b0, pend)
        strobe(2'h1, 2'h0);
        wr(RQH, 4'h0);
        wr(ENH, 4'h0);
        for (int i = 0; i < 3; i++)
        begin
            wr(M1A, mode[i]);
            wr(RQL, 4'h0);
            lvl(1, 1'b1, 5);
            lvl(1, 1'b0, 5);
            rdc("pin1 mode", RQL, exp[i]);
        end
        wr(M1A, 4'h0);
        wr(RQL, 4'h0);
        lvl(0, 1'b1, 0);
        lvl(0, 1'b0, 5);
        rdc("pin0 short", RQL, 4'h0);
        lvl(0, 1'b1, 3);
        lvl(0, 1'b0, 5);
        rdc("pin0 long", RQL, 4'h4);
        wr(RQL, 4'h0);
        @(posedge clk);
        standby <= 1'b1;
        lvl(0, 1'b1, 4);
        lvl(0, 1'b0, 4);
        standby <= 1'b0;
        repeat (5) @(posedge clk);
        rdc("pin0 standby", RQL, 4'h0);
        wr(M0A, 4'h8);
        repeat (16) @(posedge clk);
        wr(RQL, 4'h0);
        lvl(0, 1'b1, 3);
        lvl(0, 1'b0, 140);
        rdc("pin0 slow short", RQL, 4'h0);
        lvl(0, 1'b1, 140);
        lvl(0, 1'b0, 140);
        rdc("pin0 slow long", RQL, 4'h4);
        $display("test pins done");
    endtask : t_pins

    initial
    begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_walk();
        t_prio();
        t_shared();
        t_pins();
        close_out();
    end
endmodule : tb
